/* rtl/sdio_top.v */
// control-port digital io and fault logic of a dc supply
// Contract
// RULE_01 - low aux rail on when its command or enable input is high
// RULE_02 - high aux rail on when its command or enable input is high
// RULE_03 - mode output one low in cv, high in cc
// RULE_04 - mode output two high only in cp
// RULE_05 - mode query gives 0 cv, 1 cc, 2 cp; outputs agree
// RULE_06 - isolation relay high when its input or command is high
// RULE_07 - polarity relay high when its input or command is high
// RULE_08 - each general input query returns its present level
// RULE_09 - fault output high when any fault bit is set
// RULE_10 - mode bits 0, 1 and 2 never raise the fault output
// RULE_11 - bit 3 set while output voltage exceeds trip limit
// RULE_12 - bit 4 set while internal temperature exceeds limit
// RULE_13 - bit 5 set when shutdown contacts are open
// RULE_14 - bit 6 set on a foldback trip
// RULE_15 - bit 7 set on a bad or out-of-limit command
// RULE_16 - bit 8 set when the fan is not running properly
// RULE_17 - bit 9 set while line voltage is out of range
// RULE_18 - bit 10 set on an internal power module fault
// RULE_19 - condition register is 32 bits, live, 1 means fault
// RULE_20 - every external input passes a two-stage synchroniser; only the six connector inputs do, condition sources go in unsynchronised
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_top (
    // clock and reset
    input  wire        clk_in,
    input  wire        nrst_in,
    // command side: levels held by the command parser
    input  wire        aux_low_rail_on_command_in,
    input  wire        aux_high_rail_on_command_in,
    input  wire        isolation_relay_command_in,
    input  wire        polarity_relay_command_in,
    input  wire [1:0]  regulation_mode_in,
    // connector digital inputs (asynchronous levels)
    input  wire        aux_low_rail_enable_in,
    input  wire        aux_high_rail_enable_in,
    input  wire        general_input_one_in,
    input  wire        general_input_two_in,
    input  wire        isolation_relay_request_in,
    input  wire        polarity_relay_request_in,
    // condition sources from the power hardware
    input  wire        overvoltage_trip_in,
    input  wire        over_temp_in,
    input  wire        shutdown_closed_in,
    input  wire        foldback_trip_in,
    input  wire        prog_error_in,
    input  wire        fan_fault_in,
    input  wire        line_fault_in,
    input  wire        module_fault_in,
    // connector outputs
    output reg         aux_low_rail_out,
    output reg         aux_high_rail_out,
    output reg         mode_one_out,
    output reg         mode_two_out,
    output reg         isolation_relay_drive_out,
    output reg         polarity_relay_drive_out,
    output wire        fault_out,
    // query answers to the command parser
    output reg  [1:0]  operating_mode_query_out,
    output reg  [3:0]  general_input_query_out,
    output wire [31:0] protection_condition_out
);
    wire [`SDIO_NUM_SYNC-1:0] raw_pins;
    wire [`SDIO_NUM_SYNC-1:0] pins;
    reg  [1:0]                mode_code;

    // all connector inputs go through the synchroniser bank
    assign raw_pins = {polarity_relay_request_in, isolation_relay_request_in,
                       general_input_two_in, general_input_one_in,
                       aux_high_rail_enable_in, aux_low_rail_enable_in};

    sdio_sync u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .raw_in   (raw_pins),
        .sync_out (pins)     // [RULE_20]
    );

    // undefined code 3 is taken as cv so outputs stay consistent
    always @* begin
        if (regulation_mode_in == `SDIO_MODE_CC) begin
            mode_code = `SDIO_MODE_CC;
        end else if (regulation_mode_in == `SDIO_MODE_CP) begin
            mode_code = `SDIO_MODE_CP;
        end else begin
            mode_code = `SDIO_MODE_CV;
        end
    end

    // registered outputs; query and pins share one source
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aux_low_rail_out          <= 1'b0;
            aux_high_rail_out         <= 1'b0;
            mode_one_out              <= 1'b0;
            mode_two_out              <= 1'b0;
            isolation_relay_drive_out <= 1'b0;
            polarity_relay_drive_out  <= 1'b0;
            operating_mode_query_out  <= `SDIO_MODE_CV;
            general_input_query_out   <= 4'h0;
        end else begin
            aux_low_rail_out  <= aux_low_rail_on_command_in
                                 | pins[0];        // [RULE_01]
            aux_high_rail_out <= aux_high_rail_on_command_in
                                 | pins[1];        // [RULE_02]
            mode_one_out <= (mode_code == `SDIO_MODE_CC); // [RULE_03]
            mode_two_out <= (mode_code == `SDIO_MODE_CP); // [RULE_04]
            operating_mode_query_out <= mode_code;        // [RULE_05]
            isolation_relay_drive_out <= isolation_relay_command_in
                                         | pins[4];        // [RULE_06]
            polarity_relay_drive_out  <= polarity_relay_command_in
                                         | pins[5];        // [RULE_07]
            general_input_query_out <= pins[5:2];          // [RULE_08]
        end
    end

    // live condition word and the fault pin derived from it
    sdio_cond u_cond (
        .clk_in              (clk_in),
        .nrst_in             (nrst_in),
        .mode_in             (mode_code),
        .overvoltage_trip_in (overvoltage_trip_in),
        .over_temp_in        (over_temp_in),
        .shutdown_closed_in  (shutdown_closed_in),
        .foldback_trip_in    (foldback_trip_in),
        .prog_error_in       (prog_error_in),
        .fan_fault_in        (fan_fault_in),
        .line_fault_in       (line_fault_in),
        .module_fault_in     (module_fault_in),
        .cond_out            (protection_condition_out),
        .fault_out           (fault_out)
    );
endmodule

/* rtl/sdio_consts.vh */
// constants for the supply digital io and fault logic
`ifndef SDIO_CONSTS_VH
`define SDIO_CONSTS_VH
// operating mode codes returned by the mode query
`define SDIO_MODE_CV        2'h0
`define SDIO_MODE_CC        2'h1
`define SDIO_MODE_CP        2'h2
// protection condition bit positions
`define SDIO_BIT_CV         0
`define SDIO_BIT_CC         1
`define SDIO_BIT_CP         2
`define SDIO_BIT_OVP        3
`define SDIO_BIT_TEMP       4
`define SDIO_BIT_SHUTDOWN   5
`define SDIO_BIT_FOLDBACK   6
`define SDIO_BIT_PROG_ERR   7
`define SDIO_BIT_FAN        8
`define SDIO_BIT_LINE       9
`define SDIO_BIT_MODULE     10
// mask of the fault bits that drive the fault pin (bits 3..10)
`define SDIO_FAULT_MASK     32'h000007f8
// reset value of the protection condition register
`define SDIO_COND_RESET     32'h00000000
// number of synchronised external inputs
`define SDIO_NUM_SYNC       6
`endif

/* rtl/sdio_sync.v */
// two-stage synchroniser bank for the external digital inputs
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_sync (
    // clock and reset
    input  wire                     clk_in,
    input  wire                     nrst_in,
    // raw and synchronised levels
    input  wire [`SDIO_NUM_SYNC-1:0] raw_in,
    output wire [`SDIO_NUM_SYNC-1:0] sync_out
);
    reg [`SDIO_NUM_SYNC-1:0] stage_one;
    reg [`SDIO_NUM_SYNC-1:0] stage_two;

    genvar i;
    generate
        for (i = 0; i < `SDIO_NUM_SYNC; i = i + 1) begin : g_sync
            // first stage feeds only the second stage
            always @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    stage_one[i] <= 1'b0;
                    stage_two[i] <= 1'b0;
                end else begin
                    stage_one[i] <= raw_in[i];
                    stage_two[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage_two;
endmodule

/* rtl/sdio_cond.v */
// protection condition register: live, unlatched status word
`timescale 1ns/1ps
`include "sdio_consts.vh"
module sdio_cond (
    // clock and reset
    input  wire        clk_in,
    input  wire        nrst_in,
    // live condition sources
    input  wire [1:0]  mode_in,
    input  wire        overvoltage_trip_in,
    input  wire        over_temp_in,
    input  wire        shutdown_closed_in,
    input  wire        foldback_trip_in,
    input  wire        prog_error_in,
    input  wire        fan_fault_in,
    input  wire        line_fault_in,
    input  wire        module_fault_in,
    // registered word and fault level
    output reg  [31:0] cond_out,
    output reg         fault_out
);
    reg [31:0] next_cond;

    // build the word from present conditions, nothing is held
    always @* begin
        next_cond = `SDIO_COND_RESET;
        next_cond[`SDIO_BIT_CV] = (mode_in == `SDIO_MODE_CV);
        next_cond[`SDIO_BIT_CC] = (mode_in == `SDIO_MODE_CC);
        next_cond[`SDIO_BIT_CP] = (mode_in == `SDIO_MODE_CP);
        next_cond[`SDIO_BIT_OVP]      = overvoltage_trip_in; // [RULE_11]
        next_cond[`SDIO_BIT_TEMP]     = over_temp_in;        // [RULE_12]
        next_cond[`SDIO_BIT_SHUTDOWN] = ~shutdown_closed_in; // [RULE_13]
        next_cond[`SDIO_BIT_FOLDBACK] = foldback_trip_in;    // [RULE_14]
        next_cond[`SDIO_BIT_PROG_ERR] = prog_error_in;       // [RULE_15]
        next_cond[`SDIO_BIT_FAN]      = fan_fault_in;        // [RULE_16]
        next_cond[`SDIO_BIT_LINE]     = line_fault_in;       // [RULE_17]
        next_cond[`SDIO_BIT_MODULE]   = module_fault_in;     // [RULE_18]
    end

    // word and fault pin update together so they never disagree
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cond_out  <= `SDIO_COND_RESET;
            fault_out <= 1'b0;
        end else begin
            cond_out  <= next_cond; // [RULE_19]
            // mode bits 0..2 are masked off the fault pin
            fault_out <= |(next_cond
                           & `SDIO_FAULT_MASK);   // [RULE_09] [RULE_10]
        end
    end
endmodule

/* test/sdio_conn_model.sv */
// switch bank and contact pair on the control connector
`timescale 1ns/1ps
module sdio_conn_model (
    // switch settings from the bench
    input  wire [5:0] sw_in,
    input  wire       open_in,
    // levels seen at the connector pins
    output wire [5:0] pin_out,
    output wire       closed_out
);
    // plain switches hold a level until moved, no bounce modelled
    assign pin_out = sw_in;
    assign closed_out = ~open_in;
endmodule

/* test/sdio_check_properties.sv */
// port checker for the supply digital io and fault logic
`timescale 1ns/1ps
module sdio_check (
    // clock and reset
    input wire        clk_in, nrst_in,
    // command side and connector pins
    input wire        aux_low_rail_on_command_in, aux_high_rail_on_command_in,
    input wire        isolation_relay_command_in, polarity_relay_command_in,
    input wire [1:0]  regulation_mode_in,
    input wire        aux_low_rail_enable_in, aux_high_rail_enable_in,
    input wire        general_input_one_in, general_input_two_in,
    input wire        isolation_relay_request_in, polarity_relay_request_in,
    // condition sources
    input wire        overvoltage_trip_in, over_temp_in, shutdown_closed_in,
    input wire        foldback_trip_in, prog_error_in, fan_fault_in,
    input wire        line_fault_in, module_fault_in,
    // outputs
    input wire        aux_low_rail_out, aux_high_rail_out, fault_out,
    input wire        mode_one_out, mode_two_out,
    input wire        isolation_relay_drive_out, polarity_relay_drive_out,
    input wire [1:0]  operating_mode_query_out,
    input wire [3:0]  general_input_query_out,
    input wire [31:0] protection_condition_out
);
    reg  [1:0]  run_cnt;
    reg  [31:0] exp_cond;
    wire        up = (run_cnt == 2'h3);
    // settle count: past values from inside reset mean nothing
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            run_cnt <= 2'h0;
        else if (!up)
            run_cnt <= run_cnt + 2'h1;
    end
    // live condition word; mode 3 reads as cv
    always @* begin
        exp_cond = {21'h0, module_fault_in, line_fault_in, fan_fault_in,
            prog_error_in, foldback_trip_in, !shutdown_closed_in,
            over_temp_in, overvoltage_trip_in, regulation_mode_in == 2'h2,
            regulation_mode_in == 2'h1,
            regulation_mode_in[0] == regulation_mode_in[1]};
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_low; up |-> aux_low_rail_out == ($past(
        aux_low_rail_on_command_in) | $past(aux_low_rail_enable_in, 3));
    endproperty
    a_low: assert property (p_low) else $error("low rail wrong");
    property p_high; up |-> aux_high_rail_out == ($past(
        aux_high_rail_on_command_in) | $past(aux_high_rail_enable_in, 3));
    endproperty
    a_high: assert property (p_high) else $error("high rail");
    property p_one; up |-> mode_one_out == ($past(regulation_mode_in) == 2'h1);
    endproperty
    a_one: assert property (p_one) else $error("mode one wrong");
    property p_two; up |-> mode_two_out == ($past(regulation_mode_in) == 2'h2);
    endproperty
    a_two: assert property (p_two) else $error("mode two wrong");
    property p_qry; operating_mode_query_out == {mode_two_out, mode_one_out};
    endproperty
    a_qry: assert property (p_qry) else $error("query disagrees");
    property p_iso; up |-> isolation_relay_drive_out == ($past(
        isolation_relay_command_in) | $past(isolation_relay_request_in, 3));
    endproperty
    a_iso: assert property (p_iso) else $error("iso relay wrong");
    property p_pol; up |-> polarity_relay_drive_out == ($past(
        polarity_relay_command_in) | $past(polarity_relay_request_in, 3));
    endproperty
    a_pol: assert property (p_pol) else $error("pol relay wrong");
    property p_gin; up |-> general_input_query_out == {$past(
        polarity_relay_request_in, 3), $past(isolation_relay_request_in, 3),
        $past(general_input_two_in, 3), $past(general_input_one_in, 3)};
    endproperty
    a_gin: assert property (p_gin) else $error("input");
    property p_flt; fault_out == |(protection_condition_out & 32'h7f8);
    endproperty
    a_flt: assert property (p_flt) else $error("fault");
    property p_cnd; up |-> protection_condition_out == $past(exp_cond);
    endproperty
    a_cnd: assert property (p_cnd) else $error("cond");
endmodule

/* test/sdio_top_test.sv */
// self-checking bench for the supply digital io and fault logic
`timescale 1ns/1ps
module sdio_top_test;
    reg         clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [3:0]  cmd = 4'h0;
    reg  [1:0]  mode = 2'h0;
    reg  [5:0]  sw = 6'h0;
    reg  [7:0]  flt = 8'h0;
    integer     error_cnt = 0;
    integer     checks_done = 0;
    wire [5:0]  pin;
    wire [3:0]  drv;
    wire [3:0]  gq;
    wire [1:0]  mq;
    wire [31:0] cond;
    wire        m1, m2, fault, closed;
    // free-running 250 MHz clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    sdio_conn_model u_conn (.sw_in(sw), .open_in(flt[2]), .pin_out(pin),
        .closed_out(closed));
    sdio_top u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .aux_low_rail_on_command_in(cmd[0]),
        .aux_high_rail_on_command_in(cmd[1]),
        .isolation_relay_command_in(cmd[2]),
        .polarity_relay_command_in(cmd[3]),
        .regulation_mode_in(mode), .aux_low_rail_enable_in(pin[0]),
        .aux_high_rail_enable_in(pin[1]), .general_input_one_in(pin[2]),
        .general_input_two_in(pin[3]), .isolation_relay_request_in(pin[4]),
        .polarity_relay_request_in(pin[5]), .overvoltage_trip_in(flt[0]),
        .over_temp_in(flt[1]), .shutdown_closed_in(closed),
        .foldback_trip_in(flt[3]), .prog_error_in(flt[4]),
        .fan_fault_in(flt[5]), .line_fault_in(flt[6]),
        .module_fault_in(flt[7]), .aux_low_rail_out(drv[0]),
        .aux_high_rail_out(drv[1]), .mode_one_out(m1), .mode_two_out(m2),
        .isolation_relay_drive_out(drv[2]), .polarity_relay_drive_out(drv[3]),
        .fault_out(fault), .operating_mode_query_out(mq),
        .general_input_query_out(gq), .protection_condition_out(cond));
    // wait edges, then step off the edge so outputs have settled
    task step(input integer n);
        begin
            repeat (n) @(posedge clk_in);
            #1;
        end
    endtask
    // wide enough for the fault pin, the word and the drives together
    task chk(input [39:0] got, input [39:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // every mode code, including the unused one
    task t_mode;
        integer   i;
        reg [1:0] em;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                em = (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0;
                @(posedge clk_in);
                mode <= i[1:0];
                step(2);
                chk({m2, m1}, em);
                chk(mq, em);
                chk({fault, cond[2:0]}, 4'h1 << em);
            end
            @(posedge clk_in);
            mode <= 2'h0;
        end
    endtask
    // one command at a time, ending with all off
    task t_cmd;
        integer   i;
        reg [3:0] e;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                e = 4'h1 << i;
                @(posedge clk_in);
                cmd <= e;
                step(2);
                chk(drv, e);
            end
        end
    endtask
    // one pin at a time; two edges in, the old level must still show
    task t_pins;
        integer   i;
        reg [5:0] e;
        reg [5:0] p;
        begin
            p = 6'h0;
            for (i = 0; i < 7; i = i + 1) begin
                e = 6'h1 << i;
                @(posedge clk_in);
                sw <= e;
                step(2);
                chk(drv, {p[5], p[4], p[1], p[0]});
                step(1);
                chk(drv[1:0], e[1:0]);
                chk(drv[3:2], e[5:4]);
                chk(gq, e[5:2]);
                p = e;
            end
        end
    endtask
    // each fault alone, then all with cp, then a reset mid-fault
    task t_faults;
        integer   i;
        reg [7:0] f;
        begin
            for (i = 0; i < 9; i = i + 1) begin
                f = 8'h1 << i;
                @(posedge clk_in);
                flt <= f;
                step(2);
                chk(cond, {21'h0, f, 3'h1});
                chk(cond[6:4], f[3:1]);
                chk(cond[8:7], f[5:4]);
                chk(cond[10:9], f[7:6]);
                chk(fault, |f);
            end
            @(posedge clk_in);
            flt <= 8'hff;
            mode <= 2'h2;
            step(2);
            chk({fault, cond}, 33'h1000007fc);
            @(posedge clk_in);
            nrst_in <= 1'b0;
            step(1);
            chk({fault, cond, drv}, 37'h0);
            @(posedge clk_in);
            nrst_in <= 1'b1;
            flt <= 8'h0;
            mode <= 2'h0;
            // first edge after release must already show the live word
            step(1);
            chk(cond, 32'h1);
            step(3);
            chk({fault, cond, drv}, 37'h10);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (3000) @(posedge clk_in);
        error_cnt = error_cnt + 1;
        results;
    end
    initial begin
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_mode;
        t_cmd;
        t_pins;
        t_faults;
        results;
    end
endmodule
bind sdio_top sdio_check u_chk (.*);
